// *** design/uip_pkg.sv ***
/*
 Constants, types and register map of the underimpedance stage.
 Assumes one clock; measurement, blocking and time stamp come from
 logic on that clock.
*/
// Overview of operation
// - Pick up when impedance below setting
// - Release above 103 percent of setting
// - Evaluate every loop each program cycle
// - Mode selects phase-earth, phase-phase, positive sequence
// - Sample block input at cycle start
// - Unblocked pick-up raises start, starts timing
// - Blocked pick-up raises blocked, nothing more
// - Block drops start, timer resets
// - Definite-time delay only
// - Global forcing overrides stage condition
// - Time-stamped ON/OFF events per stage
// - Mask selects ON, OFF or both
// - Clearable start, trip, blocked counters
// - Twelve newest records, oldest overwritten
// - Records only on ON transitions
// - Record holds stamps, impedances, remaining time
// - Record holds loop type and group
// - Report lowest impedance to setting ratio
// - Report expected and remaining time
// - Active group settings apply immediately
package uip_pkg;
	localparam int TICK_MS      = 5;
	localparam int PRE_TRIG_MS  = 20;
	localparam int PRE_FAULT_MS = 200;
	localparam int HIST_DEPTH   = PRE_FAULT_MS / TICK_MS;
	localparam int REC_DEPTH    = 12;
	localparam int GROUPS       = 8;
	localparam int GRP_W        = 3;
	localparam int Z_W          = 16;
	localparam int DLY_W        = 19;
	localparam int CNT_W        = 16;
	localparam int DIV_W        = 32;
	localparam int DEN_W        = 18;
	localparam int REM_W        = DEN_W + 1;
	localparam logic [5:0] HIST_LAST  = 6'(HIST_DEPTH - 1);
	localparam logic [5:0] PRE_TRIG   = 6'(PRE_TRIG_MS / TICK_MS);
	localparam logic [3:0] REC_LAST   = 4'(REC_DEPTH - 1);
	localparam logic [4:0] REC_NUM    = 5'(REC_DEPTH);
	localparam logic [5:0] DIV_STEPS  = 6'(DIV_W);
	localparam logic [1:0] LOOP_LAST  = 2'h2;
	localparam logic [31:0] Z_SCALE   = 32'h0000_03E8;
	localparam logic [31:0] R_SCALE   = 32'h0000_0064;
	localparam logic [23:0] RESET_DEN = 24'h00_0064;
	localparam logic [23:0] RESET_NUM = 24'h00_0067;
	localparam logic [Z_W-1:0] Z_MAX        = 16'hFFFF;
	localparam logic [Z_W-1:0] ZSET_DEFAULT = 16'h03E8;
	localparam logic [DLY_W-1:0] DLY_DEFAULT = 19'h0_0008;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_GSEL   = 8'h04;
	localparam logic [7:0] OFS_ZSET   = 8'h08;
	localparam logic [7:0] OFS_DELAY  = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RATIO  = 8'h14;
	localparam logic [7:0] OFS_EXPECT = 8'h18;
	localparam logic [7:0] OFS_REMAIN = 8'h1C;
	localparam logic [7:0] OFS_CNT_S  = 8'h20;
	localparam logic [7:0] OFS_CNT_T  = 8'h24;
	localparam logic [7:0] OFS_CNT_B  = 8'h28;
	localparam logic [7:0] OFS_CNT_CLR = 8'h2C;
	localparam logic [7:0] OFS_REC_SEL = 8'h30;
	localparam logic [7:0] OFS_REC_TS  = 8'h34;
	localparam logic [7:0] OFS_REC_INF = 8'h38;
	localparam logic [7:0] OFS_REC_Z   = 8'h3C;
	localparam logic [7:0] OFS_REC_PF  = 8'h40;
	typedef enum logic [1:0] {MODE_PE = 2'h0, MODE_PP = 2'h1, MODE_PS = 2'h2} uip_mode_t;
	typedef enum logic [1:0] {
		COND_NORMAL = 2'h0, COND_START = 2'h1, COND_TRIP = 2'h2, COND_BLOCKED = 2'h3
	} uip_cond_t;
	typedef enum logic [1:0] {EV_START = 2'h0, EV_TRIP = 2'h1, EV_BLOCK = 2'h2} uip_ev_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1, ST_LOOP = 4'h2, ST_RATIO = 4'h4, ST_EVAL = 4'h8
	} uip_st_t;
	typedef struct packed {
		logic [2:0]       mask_off;
		logic [2:0]       mask_on;
		logic [GRP_W-1:0] group;
		uip_cond_t        force_to;
		uip_mode_t        mode;
	} uip_ctrl_t;
	localparam uip_ctrl_t CTRL_DEFAULT = '{3'h7, 3'h7, 3'h0, COND_NORMAL, MODE_PE};
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} uip_bus_t;
	typedef struct packed {
		logic [2:0][15:0] cur;
		logic [3:0][15:0] volt;
	} uip_meas_t;
	typedef struct packed {
		logic [2:0] on;
		logic [2:0] off;
	} uip_evt_t;
	typedef struct packed {
		logic [31:0]      ts;
		uip_ev_t          ev;
		uip_mode_t        mode;
		logic [1:0]       loop_idx;
		logic [GRP_W-1:0] grp;
		logic [Z_W-1:0]   z_pre;
		logic [Z_W-1:0]   z_flt;
		logic [Z_W-1:0]   z_pf;
		logic [DLY_W-1:0] remain;
	} uip_rec_t;
endpackage

// *** design/uip_stage.sv ***
/*
 One underimpedance stage: impedance evaluation, start/trip/blocked
 with definite delay, events, counters and fault records.
 Assumes meas_valid pulses once per 5 ms program cycle and that the
 bus, block input and time stamp share this clock.
*/
// Design decisions made here: the register addresses and the plain strobed port.
module uip_stage (
	input  wire logic                  clock,
	input  wire logic                  resetn,
	input  wire uip_pkg::uip_bus_t     bus,
	output logic [31:0]                rd_data,
	input  wire logic                  meas_valid,
	input  wire uip_pkg::uip_meas_t    meas,
	input  wire logic                  block_in,
	input  wire logic                  force_enable,
	input  wire logic [31:0]           timestamp,
	output logic                       start,
	output logic                       trip,
	output logic                       blocked,
	output uip_pkg::uip_evt_t          events,
	output logic [31:0]                event_stamp
);
	uip_pkg::uip_ctrl_t                ctrl_q;
	logic [uip_pkg::GRP_W-1:0]         gsel_q;
	logic [uip_pkg::Z_W-1:0]           zset_q [uip_pkg::GROUPS];
	logic [uip_pkg::DLY_W-1:0]         dly_q [uip_pkg::GROUPS];
	logic [3:0]                        rsel_q;
	uip_pkg::uip_st_t                  st_q;
	uip_pkg::uip_meas_t                meas_q;
	logic                              blk_q;
	logic [1:0]                        lp_q;
	logic [1:0]                        zloop_q;
	logic [uip_pkg::Z_W-1:0]           zmin_q;
	logic [uip_pkg::Z_W-1:0]           ratio_q;
	logic                              pick_q;
	logic [uip_pkg::DLY_W-1:0]         elap_q;
	logic                              div_load_q;
	logic [5:0]                        div_cnt_q;
	logic [uip_pkg::DIV_W-1:0]         num_q;
	logic [uip_pkg::DIV_W-1:0]         quo_q;
	logic [uip_pkg::DEN_W-1:0]         den_q;
	logic [uip_pkg::REM_W-1:0]         rem_q;
	logic [uip_pkg::Z_W-1:0]           hist_q [uip_pkg::HIST_DEPTH];
	logic [5:0]                        hp_q;
	uip_pkg::uip_rec_t                 rec_q [uip_pkg::REC_DEPTH];
	logic [3:0]                        rwp_q;
	logic [2:0][uip_pkg::CNT_W-1:0]    cnt_q;
	logic [31:0]                       rd_q;
	logic                              start_q;
	logic                              trip_q;
	logic                              blocked_q;
	uip_pkg::uip_evt_t                 evt_q;
	logic [31:0]                       stamp_q;

	assign rd_data     = rd_q;
	assign start       = start_q;
	assign trip        = trip_q;
	assign blocked     = blocked_q;
	assign events      = evt_q;
	assign event_stamp = stamp_q;

	// Bus decode
	wire wr_ctrl = bus.wr && bus.addr == uip_pkg::OFS_CTRL;
	wire wr_gsel = bus.wr && bus.addr == uip_pkg::OFS_GSEL;
	wire wr_zset = bus.wr && bus.addr == uip_pkg::OFS_ZSET;
	wire wr_dly  = bus.wr && bus.addr == uip_pkg::OFS_DELAY;
	wire wr_clr  = bus.wr && bus.addr == uip_pkg::OFS_CNT_CLR;
	wire wr_rsel = bus.wr && bus.addr == uip_pkg::OFS_REC_SEL;

	// Active group is read live, so a group change needs no restart
	wire [uip_pkg::Z_W-1:0]   zset_act = zset_q[ctrl_q.group];
	wire [uip_pkg::DLY_W-1:0] dly_act  = dly_q[ctrl_q.group];
	wire uip_pkg::uip_mode_t  mode     = ctrl_q.mode;

	// Loop operands; U in 10 mV, I in mA gives Z in 0.01 ohm
	wire [15:0] u_k = meas_q.volt[lp_q];
	wire [15:0] i_k = meas_q.cur[lp_q];
	wire [17:0] u_sum = 18'(meas_q.volt[0]) + 18'(meas_q.volt[1]) + 18'(meas_q.volt[2]);
	wire [17:0] i_sum = 18'(meas_q.cur[0]) + 18'(meas_q.cur[1]) + 18'(meas_q.cur[2]);
	// Magnitude-only model: phase pair loop sees twice the phase current,
	// positive sequence uses the three-phase sums
	wire [31:0] loop_num = (mode == uip_pkg::MODE_PS) ? 32'(u_sum) * uip_pkg::Z_SCALE
		: 32'(u_k) * uip_pkg::Z_SCALE;
	wire [17:0] loop_den = (mode == uip_pkg::MODE_PS) ? i_sum
		: (mode == uip_pkg::MODE_PP) ? {1'b0, i_k, 1'b0} : 18'(i_k);
	wire loop_last = mode == uip_pkg::MODE_PS || lp_q == uip_pkg::LOOP_LAST;
	wire [31:0] ratio_num = 32'(zmin_q) * uip_pkg::R_SCALE;
	wire is_ratio = st_q == uip_pkg::ST_RATIO;
	wire [31:0] sel_num = is_ratio ? ratio_num : loop_num;
	wire [17:0] sel_den = is_ratio ? 18'(zset_act) : loop_den;

	// Serial restoring divider; zero divisor saturates the result
	wire [uip_pkg::REM_W-1:0] rem_sh = {rem_q[uip_pkg::REM_W-2:0], num_q[uip_pkg::DIV_W-1]};
	wire q_bit = rem_sh >= {1'b0, den_q};
	wire [uip_pkg::REM_W-1:0] rem_nx = q_bit ? rem_sh - {1'b0, den_q} : rem_sh;
	wire div_busy = div_load_q || div_cnt_q != 6'h00;
	wire [uip_pkg::Z_W-1:0] div_res = (|quo_q[31:16]) ? uip_pkg::Z_MAX : quo_q[15:0];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			num_q     <= '0;
			den_q     <= '0;
			rem_q     <= '0;
			quo_q     <= '0;
			div_cnt_q <= '0;
		end else if (div_load_q) begin
			num_q     <= sel_num;
			den_q     <= sel_den;
			rem_q     <= '0;
			quo_q     <= '0;
			div_cnt_q <= uip_pkg::DIV_STEPS;
		end else if (div_cnt_q != 6'h00) begin
			num_q     <= {num_q[uip_pkg::DIV_W-2:0], 1'b0};
			rem_q     <= rem_nx;
			quo_q     <= {quo_q[uip_pkg::DIV_W-2:0], q_bit};
			div_cnt_q <= div_cnt_q - 6'h01;
		end
	end

	// Pick-up with fixed 103 % release hysteresis
	wire z_below = zmin_q < zset_act;
	wire z_above = 24'(zmin_q) * uip_pkg::RESET_DEN > 24'(zset_act) * uip_pkg::RESET_NUM;
	wire pick_d  = pick_q ? !z_above : z_below;
	wire run_d   = pick_d && !blk_q;
	wire [uip_pkg::DLY_W-1:0] elap_d = !run_d ? '0
		: !start_q ? '0
		: (elap_q >= dly_act) ? elap_q : elap_q + 19'h0_0001;
	wire forced = force_enable && ctrl_q.force_to != uip_pkg::COND_NORMAL;
	wire trip_n  = forced ? ctrl_q.force_to == uip_pkg::COND_TRIP
		: run_d && elap_d >= dly_act;
	wire start_n = forced ? ctrl_q.force_to == uip_pkg::COND_START || trip_n
		: run_d;
	wire blk_n   = forced ? ctrl_q.force_to == uip_pkg::COND_BLOCKED
		: pick_d && blk_q;
	wire [2:0] now_v  = {blk_n, trip_n, start_n};
	wire [2:0] was_v  = {blocked_q, trip_q, start_q};
	wire [2:0] on_v   = now_v & ~was_v;
	wire [2:0] off_v  = ~now_v & was_v;
	wire is_eval = st_q == uip_pkg::ST_EVAL;
	wire [uip_pkg::DLY_W-1:0] remain_now = start_q ? dly_act - elap_q : '0;

	// History of lowest impedance, one entry per program cycle
	wire [5:0] pre_idx = (hp_q >= uip_pkg::PRE_TRIG) ? hp_q - uip_pkg::PRE_TRIG
		: hp_q + uip_pkg::HIST_LAST + 6'h01 - uip_pkg::PRE_TRIG;
	wire [5:0] hp_nx = (hp_q == uip_pkg::HIST_LAST) ? 6'h00 : hp_q + 6'h01;
	wire uip_pkg::uip_ev_t rec_ev = on_v[uip_pkg::EV_TRIP] ? uip_pkg::EV_TRIP
		: on_v[uip_pkg::EV_START] ? uip_pkg::EV_START : uip_pkg::EV_BLOCK;
	wire rec_we = is_eval && |on_v;
	wire uip_pkg::uip_rec_t rec_new = '{
		ts: timestamp, ev: rec_ev, mode: mode, loop_idx: zloop_q, grp: ctrl_q.group,
		z_pre: hist_q[pre_idx], z_flt: zmin_q, z_pf: hist_q[hp_q],
		remain: run_d ? dly_act - elap_d : '0};
	wire [3:0] rwp_nx = (rwp_q == uip_pkg::REC_LAST) ? 4'h0 : rwp_q + 4'h1;

	// Processing sequence of one program cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_q       <= uip_pkg::ST_IDLE;
			meas_q     <= '0;
			blk_q      <= 1'b0;
			lp_q       <= '0;
			zloop_q    <= '0;
			zmin_q     <= uip_pkg::Z_MAX;
			ratio_q    <= '0;
			div_load_q <= 1'b0;
		end else begin
			div_load_q <= 1'b0;
			unique case (st_q)
				uip_pkg::ST_IDLE: if (meas_valid) begin
					meas_q     <= meas;
					blk_q      <= block_in;
					lp_q       <= '0;
					zmin_q     <= uip_pkg::Z_MAX;
					div_load_q <= 1'b1;
					st_q       <= uip_pkg::ST_LOOP;
				end
				uip_pkg::ST_LOOP: if (!div_busy) begin
					if (div_res < zmin_q) begin
						zmin_q  <= div_res;
						zloop_q <= lp_q;
					end
					lp_q       <= lp_q + 2'h1;
					div_load_q <= 1'b1;
					st_q       <= loop_last ? uip_pkg::ST_RATIO : uip_pkg::ST_LOOP;
				end
				uip_pkg::ST_RATIO: if (!div_busy) begin
					ratio_q <= div_res;
					st_q    <= uip_pkg::ST_EVAL;
				end
				uip_pkg::ST_EVAL: st_q <= uip_pkg::ST_IDLE;
			endcase
		end
	end

	// Stage condition, updated once per program cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pick_q    <= 1'b0;
			elap_q    <= '0;
			start_q   <= 1'b0;
			trip_q    <= 1'b0;
			blocked_q <= 1'b0;
		end else if (is_eval) begin
			pick_q    <= pick_d;
			elap_q    <= forced ? '0 : elap_d;
			start_q   <= start_n;
			trip_q    <= trip_n;
			blocked_q <= blk_n;
		end
	end

	// Events carry the stamp of the cycle that produced them
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			evt_q   <= '0;
			stamp_q <= '0;
		end else begin
			evt_q.on  <= is_eval ? on_v & ctrl_q.mask_on : 3'h0;
			evt_q.off <= is_eval ? off_v & ctrl_q.mask_off : 3'h0;
			if (is_eval) begin
				stamp_q <= timestamp;
			end
		end
	end

	function automatic logic [uip_pkg::CNT_W-1:0] cnt_inc(input logic inc);
		return inc ? 16'h0001 : 16'h0000;
	endfunction

	// Counters: an increment in the clear cycle survives
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_cnt
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					cnt_q[gi] <= '0;
				end else begin
					cnt_q[gi] <= ((wr_clr && bus.wdata[gi]) ? '0 : cnt_q[gi])
						+ cnt_inc(is_eval && on_v[gi]);
				end
			end
		end
		for (gi = 0; gi < uip_pkg::GROUPS; gi++) begin : g_grp
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					zset_q[gi] <= uip_pkg::ZSET_DEFAULT;
					dly_q[gi]  <= uip_pkg::DLY_DEFAULT;
				end else if (gsel_q == 3'(gi)) begin
					if (wr_zset) begin
						zset_q[gi] <= bus.wdata[uip_pkg::Z_W-1:0];
					end
					if (wr_dly) begin
						dly_q[gi] <= bus.wdata[uip_pkg::DLY_W-1:0];
					end
				end
			end
		end
		for (gi = 0; gi < uip_pkg::HIST_DEPTH; gi++) begin : g_hist
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					hist_q[gi] <= uip_pkg::Z_MAX;
				end else if (is_eval && hp_q == 6'(gi)) begin
					hist_q[gi] <= zmin_q;
				end
			end
		end
		for (gi = 0; gi < uip_pkg::REC_DEPTH; gi++) begin : g_rec
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					rec_q[gi] <= '0;
				end else if (rec_we && rwp_q == 4'(gi)) begin
					rec_q[gi] <= rec_new;
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hp_q  <= '0;
			rwp_q <= '0;
		end else begin
			if (is_eval) begin
				hp_q <= hp_nx;
			end
			if (rec_we) begin
				rwp_q <= rwp_nx;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= uip_pkg::CTRL_DEFAULT;
			gsel_q <= '0;
			rsel_q <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= uip_pkg::uip_ctrl_t'(bus.wdata[$bits(uip_pkg::uip_ctrl_t)-1:0]);
			end
			if (wr_gsel) begin
				gsel_q <= bus.wdata[uip_pkg::GRP_W-1:0];
			end
			if (wr_rsel) begin
				rsel_q <= bus.wdata[3:0];
			end
		end
	end

	// Record select 0 is the newest record
	wire [4:0] rix_t = 5'(rwp_q) + 5'(uip_pkg::REC_LAST) - 5'(rsel_q);
	wire [3:0] rix = (rix_t >= uip_pkg::REC_NUM) ? 4'(rix_t - uip_pkg::REC_NUM) : rix_t[3:0];
	wire uip_pkg::uip_rec_t rsel = rec_q[rix];
	wire [31:0] rd_mux =
		(bus.addr == uip_pkg::OFS_CTRL)    ? 32'(ctrl_q) :
		(bus.addr == uip_pkg::OFS_GSEL)    ? 32'(gsel_q) :
		(bus.addr == uip_pkg::OFS_ZSET)    ? 32'(zset_q[gsel_q]) :
		(bus.addr == uip_pkg::OFS_DELAY)   ? 32'(dly_q[gsel_q]) :
		(bus.addr == uip_pkg::OFS_STATUS)  ? 32'({pick_q, blocked_q, trip_q, start_q}) :
		(bus.addr == uip_pkg::OFS_RATIO)   ? 32'(ratio_q) :
		(bus.addr == uip_pkg::OFS_EXPECT)  ? 32'(dly_act) :
		(bus.addr == uip_pkg::OFS_REMAIN)  ? 32'(remain_now) :
		(bus.addr == uip_pkg::OFS_CNT_S)   ? 32'(cnt_q[uip_pkg::EV_START]) :
		(bus.addr == uip_pkg::OFS_CNT_T)   ? 32'(cnt_q[uip_pkg::EV_TRIP]) :
		(bus.addr == uip_pkg::OFS_CNT_B)   ? 32'(cnt_q[uip_pkg::EV_BLOCK]) :
		(bus.addr == uip_pkg::OFS_REC_SEL) ? 32'(rsel_q) :
		(bus.addr == uip_pkg::OFS_REC_TS)  ? rsel.ts :
		(bus.addr == uip_pkg::OFS_REC_INF) ?
			32'({rsel.ev, rsel.mode, rsel.loop_idx, rsel.grp, rsel.remain}) :
		(bus.addr == uip_pkg::OFS_REC_Z)   ? {rsel.z_pre, rsel.z_flt} :
		(bus.addr == uip_pkg::OFS_REC_PF)  ? 32'(rsel.z_pf) : 32'h0000_0000;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rd_q <= '0;
		end else begin
			rd_q <= bus.rd ? rd_mux : 32'h0000_0000;
		end
	end
endmodule

// *** sim/uip_stage_props.sv ***
/*
 Concurrent checks on the ports of one underimpedance stage.
 Assumes the single clock and the async active-low reset of the stage.
*/
module uip_stage_props (
	input wire logic               clock,
	input wire logic               resetn,
	input wire uip_pkg::uip_bus_t  bus,
	input wire logic [31:0]        rd_data,
	input wire logic               meas_valid,
	input wire uip_pkg::uip_meas_t meas,
	input wire logic               block_in,
	input wire logic               force_enable,
	input wire logic [31:0]        timestamp,
	input wire logic               start,
	input wire logic               trip,
	input wire logic               blocked,
	input wire uip_pkg::uip_evt_t  events,
	input wire logic [31:0]        event_stamp
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	AST_RD_IDLE: assert property (!$past(bus.rd) |-> rd_data == 32'h0)
		else $error("read data outside its slot");
	AST_HOLD: assert property (meas_valid |=> $stable({start, trip, blocked})[*8])
		else $error("status moved right after measurement");
	AST_EV_PULSE: assert property ((events != '0) |=> (events == '0))
		else $error("event longer than one cycle");
	AST_ON_START: assert property (events.on[0] |-> $rose(start))
		else $error("start on event without rise");
	AST_OFF_START: assert property (events.off[0] |-> $fell(start))
		else $error("start off event without fall");
	AST_ON_TRIP: assert property (events.on[1] |-> $rose(trip))
		else $error("trip on event without rise");
	AST_OFF_TRIP: assert property (events.off[1] |-> $fell(trip))
		else $error("trip off event without fall");
	AST_ON_BLOCK: assert property (events.on[2] |-> $rose(blocked))
		else $error("block on event without rise");
	AST_OFF_BLOCK: assert property (events.off[2] |-> $fell(blocked))
		else $error("block off event without fall");
	AST_TRIP_START: assert property (trip |-> start)
		else $error("trip without start");
	AST_BLK_EXCL: assert property (blocked |-> !start && !trip)
		else $error("blocked together with start or trip");
	AST_STAMP: assert property ((events != '0) |-> event_stamp == $past(timestamp))
		else $error("event stamp not taken in the evaluation cycle");
endmodule

bind uip_stage uip_stage_props uip_stage_props_i (
	.clock       (clock),
	.resetn      (resetn),
	.bus         (bus),
	.rd_data     (rd_data),
	.meas_valid  (meas_valid),
	.meas        (meas),
	.block_in    (block_in),
	.force_enable(force_enable),
	.timestamp   (timestamp),
	.start       (start),
	.trip        (trip),
	.blocked     (blocked),
	.events      (events),
	.event_stamp (event_stamp)
);

// *** sim/uip_meas_model.sv ***
/*
 Measurement chain and blocking source in front of the stage.
 Assumes levels are set by the bench well away from the strobe.
*/
module uip_meas_model #(
	parameter int PERIOD = 400
) (
	input wire logic          clock,
	input wire logic          resetn,
	input wire logic [15:0]   cur_level,
	input wire logic [15:0]   volt_level,
	input wire logic          block_req,
	output logic              meas_valid,
	output uip_pkg::uip_meas_t meas,
	output logic              block_in,
	output logic [31:0]       timestamp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt_q;

	// Strobe period stands in for the 5 ms time base
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_q      <= 16'h0000;
			meas_valid <= 1'b0;
			meas       <= '0;
			block_in   <= 1'b0;
			timestamp  <= 32'h0000_0000;
		end else begin
			cnt_q      <= (cnt_q == 16'(PERIOD - 1)) ? 16'h0000 : cnt_q + 16'h0001;
			meas_valid <= (cnt_q == 16'(PERIOD - 1));
			// Unused fourth channel toggles so a stale read would show
			meas.volt  <= {~meas.volt[3], {3{volt_level}}};
			meas.cur   <= {3{cur_level}};
			block_in   <= block_req;
			timestamp  <= timestamp + 32'h0000_0001;
		end
	end
endmodule

// *** sim/uip_stage_tb_top.sv ***
/*
 Self-checking bench for one underimpedance stage.
 Assumes the measurement model strobes every 400 cycles.
*/
module uip_stage_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clock = 1'b0;
	logic              resetn = 1'b0;
	uip_pkg::uip_bus_t bus = '0;
	logic              force_enable = 1'b0;
	logic              block_req = 1'b0;
	logic [15:0]       cur_level = 16'h0064;
	logic [15:0]       volt_level = 16'h07D0;
	logic [31:0]       rd_data, event_stamp, timestamp;
	logic              meas_valid, block_in, start, trip, blocked;
	uip_pkg::uip_meas_t meas;
	uip_pkg::uip_evt_t events;
	int                err_total = 0;
	int                samples_checked = 0;
	int                cycles = 0;
	int                on_seen = 0;
	logic [31:0]       d;
	logic [2:0]        fexp [4] = '{3'h0, 3'h1, 3'h3, 3'h4};

	always #5 clock = ~clock;

	uip_meas_model uip_meas_model_i (.clock(clock), .resetn(resetn), .cur_level(cur_level),
		.volt_level(volt_level), .block_req(block_req), .meas_valid(meas_valid),
		.meas(meas), .block_in(block_in), .timestamp(timestamp));
	uip_stage uip_stage_i (.clock(clock), .resetn(resetn), .bus(bus), .rd_data(rd_data),
		.meas_valid(meas_valid), .meas(meas), .block_in(block_in),
		.force_enable(force_enable), .timestamp(timestamp), .start(start), .trip(trip),
		.blocked(blocked), .events(events), .event_stamp(event_stamp));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (events.on[0] === 1'b1)
			on_seen++;
		if (cycles == 20000) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1 d = rd_data;
		chk(d, exp);
	endtask

	// Each level meets exactly one evaluation, so delay counts stay exact
	task automatic tick(input logic [15:0] v, input logic blk, input logic [2:0] exp);
		volt_level <= v;
		block_req  <= blk;
		@(posedge clock);
		#1;
		for (int i = 0; i < 500 && meas_valid !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		repeat (200) @(posedge clock);
		#1 chk({29'h0, blocked, trip, start}, {29'h0, exp});
	endtask

	initial begin
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		rdc(uip_pkg::OFS_CTRL, 32'h0000_1F80);
		rdc(uip_pkg::OFS_ZSET, 32'h0000_03E8);
		rdc(uip_pkg::OFS_DELAY, 32'h0000_0008);
		rdc(uip_pkg::OFS_EXPECT, 32'h0000_0008);
		rdc(8'hFC, 32'h0000_0000);
		$display("defaults done");
		wr(uip_pkg::OFS_DELAY, 32'h0000_0002);
		tick(16'h0064, 1'b0, 3'h0);
		tick(16'h0063, 1'b0, 3'h1);
		rdc(uip_pkg::OFS_RATIO, 32'h0000_0063);
		rdc(uip_pkg::OFS_REMAIN, 32'h0000_0002);
		tick(16'h0066, 1'b0, 3'h1);
		tick(16'h0067, 1'b0, 3'h3);
		rdc(uip_pkg::OFS_REC_SEL, 32'h0000_0000);
		rdc(uip_pkg::OFS_REC_INF, 32'h0400_0000);
		rdc(uip_pkg::OFS_REC_Z, 32'hFFFF_0406);
		rdc(uip_pkg::OFS_REC_PF, 32'h0000_FFFF);
		tick(16'h0068, 1'b0, 3'h0);
		$display("hysteresis and delay done");
		tick(16'h0032, 1'b0, 3'h1);
		tick(16'h0032, 1'b1, 3'h4);
		tick(16'h0032, 1'b0, 3'h1);
		tick(16'h0032, 1'b0, 3'h1);
		tick(16'h0032, 1'b0, 3'h3);
		tick(16'h07D0, 1'b0, 3'h0);
		rdc(uip_pkg::OFS_CNT_S, 32'h0000_0003);
		rdc(uip_pkg::OFS_CNT_T, 32'h0000_0002);
		rdc(uip_pkg::OFS_CNT_B, 32'h0000_0001);
		wr(uip_pkg::OFS_CNT_CLR, 32'h0000_0007);
		rdc(uip_pkg::OFS_CNT_S, 32'h0000_0000);
		rdc(uip_pkg::OFS_CNT_B, 32'h0000_0000);
		$display("blocking and counters done");
		wr(uip_pkg::OFS_CTRL, 32'h0000_1C00);
		d = 32'(on_seen);
		tick(16'h0032, 1'b0, 3'h1);
		chk(32'(on_seen), d);
		tick(16'h07D0, 1'b0, 3'h0);
		$display("mask done");
		for (int m = 0; m < 3; m++) begin
			wr(uip_pkg::OFS_CTRL, 32'h0000_1F80 | 32'(m));
			tick(16'h0096, 1'b0, {2'h0, m == 1});
			tick(16'h07D0, 1'b0, 3'h0);
		end
		$display("modes done");
		wr(uip_pkg::OFS_GSEL, 32'h0000_0001);
		wr(uip_pkg::OFS_ZSET, 32'h0000_0064);
		wr(uip_pkg::OFS_CTRL, 32'h0000_1F90);
		tick(16'h0032, 1'b0, 3'h0);
		wr(uip_pkg::OFS_CTRL, 32'h0000_1F80);
		tick(16'h0032, 1'b0, 3'h1);
		tick(16'h07D0, 1'b0, 3'h0);
		$display("groups done");
		wr(uip_pkg::OFS_CTRL, 32'h0000_1F88);
		tick(16'h07D0, 1'b0, 3'h0);
		force_enable <= 1'b1;
		for (int f = 3; f >= 0; f--) begin
			wr(uip_pkg::OFS_CTRL, 32'h0000_1F80 | 32'(f << 2));
			tick(16'h07D0, 1'b0, fexp[f]);
		end
		$display("forcing done");
		end_of_test();
	end
endmodule
